// ---- logic/eis_flr.sv ----
module eis_flr (
  input  wire logic clk,       // core clock
  input  wire logic rst,       // sync reset
  input  wire logic ce,        // clock enable
  input  wire logic start,     // software asks for a function reset
  input  wire logic user_rdy,  // user logic ready for reset
  output logic      reset_req, // request toward user logic
  output logic      done       // one-cycle pulse, reset carried out
);
  import eis_pkg::*;

  typedef struct packed {
    eis_flr_state_t st;
  } eis_flr_regs_t;

  eis_flr_regs_t r_ff;
  eis_flr_regs_t nxt_r;

  always_comb begin
    nxt_r = r_ff;
    case (r_ff.st)
      FLR_IDLE: if (start) nxt_r.st = FLR_WAIT;          // see RL12
      FLR_WAIT: if (user_rdy) nxt_r.st = FLR_DONE;       // see RL13
      FLR_DONE: nxt_r.st = FLR_IDLE;
      default:  nxt_r.st = FLR_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      r_ff <= '{st: FLR_IDLE};
    end else if (ce) begin
      r_ff <= nxt_r;
    end
  end

  assign reset_req = (r_ff.st == FLR_WAIT);
  assign done      = (r_ff.st == FLR_DONE);

  AST_FLR_REQ: // see RL12
  assert property (@(posedge clk) disable iff (rst)
    ce && start && r_ff.st == FLR_IDLE |=> reset_req)
  else $error("function reset request not raised");

  AST_FLR_HOLD: // see RL12
  assert property (@(posedge clk) disable iff (rst)
    reset_req && !(ce && user_rdy) |=> reset_req)
  else $error("function reset request dropped before ready");

endmodule : eis_flr

// ---- logic/eis_intx.sv ----
module eis_intx (
  input  wire logic                   clk,         // core clock
  input  wire logic                   rst,         // sync reset
  input  wire logic                   ce,          // clock enable
  input  wire logic                   req_n,       // legacy request, low active
  input  wire logic                   int_disable, // command bit 5
  input  wire logic                   msi_on,      // msi replaces legacy
  output eis_pkg::eis_intx_msg_t      msg,         // message strobe
  output logic                        status       // interrupt status
);
  import eis_pkg::*;

  typedef struct packed {
    logic          req_n_d;
    logic          status;
    eis_intx_msg_t msg;
  } eis_intx_state_t;

  eis_intx_state_t st_ff;
  eis_intx_state_t nxt_st;
  logic            fall;
  logic            rise;
  logic            quiet;

  assign fall  = st_ff.req_n_d & ~req_n;
  assign rise  = ~st_ff.req_n_d & req_n;
  assign quiet = int_disable | msi_on;

  always_comb begin
    nxt_st           = st_ff;
    nxt_st.req_n_d   = req_n;
    nxt_st.msg.valid = 1'b0;
    // status tracks the edges even while messages are muted
    if (fall) begin
      nxt_st.status        = 1'b1;                  // see RL5 see RL7
      nxt_st.msg.valid     = ~quiet;                // see RL7 see RL15
      nxt_st.msg.is_assert = 1'b1;                  // see RL5 see RL11
    end else if (rise) begin
      nxt_st.status        = 1'b0;                  // see RL6
      nxt_st.msg.valid     = ~quiet;                // see RL7 see RL15
      nxt_st.msg.is_assert = 1'b0;                  // see RL6
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_ff <= '{req_n_d: 1'b1, status: 1'b0, msg: '{1'b0, 1'b0}};
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  assign msg    = st_ff.msg;
  assign status = st_ff.status;

  AST_INTX_ASSERT: // see RL5
  assert property (@(posedge clk) disable iff (rst)
    ce && fall && !quiet |=> msg.valid && msg.is_assert && status)
  else $error("assert message missing after falling request");

  AST_INTX_DEASSERT: // see RL6
  assert property (@(posedge clk) disable iff (rst)
    ce && rise && !quiet |=> msg.valid && !msg.is_assert && !status)
  else $error("deassert message missing after rising request");

  AST_INTX_MUTED: // see RL7
  assert property (@(posedge clk) disable iff (rst)
    ce && int_disable |=> !msg.valid)
  else $error("legacy message sent while interrupt disable set");

  AST_INTX_STATUS: // see RL7
  assert property (@(posedge clk) disable iff (rst)
    ce |=> status == !$past(req_n))
  else $error("interrupt status does not follow request");

  AST_INTX_MSI: // see RL15
  assert property (@(posedge clk) disable iff (rst)
    ce && msi_on |=> !msg.valid)
  else $error("legacy message sent while msi enabled");

endmodule : eis_intx

// ---- logic/eis_pkg.sv ----
package eis_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // register byte offsets
  localparam logic [7:0] OFF_CMD      = 8'h00;
  localparam logic [7:0] OFF_DEV_CTL  = 8'h04;
  localparam logic [7:0] OFF_LNK_CTL  = 8'h08;
  localparam logic [7:0] OFF_DEV_CTL2 = 8'h0c;
  localparam logic [7:0] OFF_MSI      = 8'h10;
  localparam logic [7:0] OFF_PM       = 8'h14;
  localparam logic [7:0] OFF_INT_STAT = 8'h18;
  localparam logic [7:0] OFF_FLR      = 8'h1c;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h20;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h24;

  // field positions
  localparam int CMD_INT_DIS  = 5;
  localparam int MSI_EN_BIT   = 0;
  localparam int MSI_CNT_LSB  = 1;
  localparam int MSI_CNT_MSB  = 3;
  localparam int PM_EN_BIT    = 0;
  localparam int PM_STAT_BIT  = 1;
  localparam int FLR_GO_BIT   = 0;
  localparam int FLR_BUSY_BIT = 1;
  localparam int IRQ_ASSERT   = 0;
  localparam int IRQ_DEASSERT = 1;
  localparam int IRQ_PME      = 2;
  localparam int IRQ_FLR      = 3;
  localparam int IRQ_W        = 4;

  // reset values
  localparam logic [5:0]       CMD_RST      = 6'h00;
  localparam logic [14:0]      DEV_CTL_RST  = 15'h0000;
  localparam logic [7:0]       LNK_CTL_RST  = 8'h00;
  localparam logic [4:0]       DEV_CTL2_RST = 5'h00;
  localparam logic             MSI_EN_RST   = 1'b0;
  localparam logic [2:0]       MSI_CNT_RST  = 3'h0;
  localparam logic             PM_EN_RST    = 1'b0;
  localparam logic [IRQ_W-1:0] IRQ_STAT_RST = 4'h0;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0;

  typedef struct packed {
    logic [5:0]  cmd;       // 5 int dis, 4 serr, 3 parity, 2 bm, 1 mem, 0 io
    logic [14:0] dev_ctl;
    logic [7:0]  lnk_ctl;
    logic [4:0]  dev_ctl2;
  } eis_mirror_t;

  typedef struct packed {
    logic valid;      // one-cycle message strobe
    logic is_assert;  // 1 assert, 0 deassert
  } eis_intx_msg_t;

  typedef enum logic [1:0] {
    FLR_IDLE = 2'b00,
    FLR_WAIT = 2'b01,
    FLR_DONE = 2'b10
  } eis_flr_state_t;

endpackage : eis_pkg

// ---- logic/eis_top.sv ----
// How it works
// RL1: command bits int disable, serr, parity, master, mem, io mirrored out.
// RL2: device control bits 14 to 0 mirrored out on the core clock.
// RL3: link control bits 7 to 0 mirrored out on the core clock.
// RL4: device control 2 bits 4 to 0 mirrored out on the core clock.
// RL5: falling request sends an assert message and sets interrupt status.
// RL6: rising request sends a deassert message and clears interrupt status.
// RL7: interrupt disable mutes messages; status still follows request.
// RL8: user spaces request edges two cycles apart in x4 and downgraded x1.
// RL9: user spaces request edges eight cycles apart in native x1.
// RL10: user raises request after disable change, e.g. OR with command bit 5.
// RL11: only one legacy interrupt line, INTA, exists.
// RL12: function reset request output raised when a function reset is due.
// RL13: user drives ready high when prepared for the function reset.
// RL14: three-bit granted msi message count is output.
// RL15: msi enabled output high means msi used, legacy request disabled.
// RL16: power event input copied into the pme status bit.
// RL17: pme enable bit output, high permits pme messages.
//
// Chosen here: the APB register port and the address map.
module eis_top (
  input  wire logic                  clk,            // core clock, 100 MHz
  input  wire logic                  rst,            // sync reset, high
  input  wire logic                  ce,             // clock enable
  input  wire logic                  psel,           // apb select
  input  wire logic                  penable,        // apb enable
  input  wire logic                  pwrite,         // apb direction
  input  wire logic [7:0]            paddr,          // apb byte address
  input  wire logic [31:0]           pwdata,         // apb write data
  output logic                       pready,         // apb ready
  output logic      [31:0]           prdata,         // apb read data
  output logic                       pslverr,        // apb error
  output logic                       irq,            // level interrupt
  input  wire logic                  inta_req_n,     // legacy request
  output eis_pkg::eis_intx_msg_t     intx_msg,       // intx message strobe
  output logic                       int_status,     // interrupt status
  output eis_pkg::eis_mirror_t       cfg_mirror,     // control mirrors
  output logic      [2:0]            granted_vector_count, // msi granted
  output logic                       msi_enabled,    // msi in use
  input  wire logic                  pme_event,      // power event input
  output logic                       pme_enable,     // pme messages allowed
  output logic                       func_reset_req, // function reset request
  input  wire logic                  func_reset_rdy  // user ready for reset
);
  import eis_pkg::*;

  typedef struct packed {
    eis_mirror_t      mirror;
    logic             msi_en;
    logic [2:0]       msi_cnt;
    logic             pme_en;
    logic             pme_stat;
    logic             pme_d;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
  } eis_regs_t;

  eis_regs_t        r_ff;
  eis_regs_t        nxt_r;
  logic             wr;
  logic             flr_start;
  logic             flr_done;
  logic             flr_rdy_seen;
  logic [IRQ_W-1:0] events;
  logic [31:0]      rdata;
  logic             unmapped;
  eis_intx_msg_t    msg;
  logic             stat;

  // zero wait states; a frozen block stalls the bus instead of losing writes
  assign pready = ce;
  assign wr     = psel & penable & pwrite & ce & ~unmapped;

  assign flr_start = wr && paddr == OFF_FLR && pwdata[FLR_GO_BIT];

  eis_intx u_intx (
    .clk         (clk),
    .rst         (rst),
    .ce          (ce),
    .req_n       (inta_req_n),
    .int_disable (r_ff.mirror.cmd[CMD_INT_DIS]),
    .msi_on      (r_ff.msi_en),
    .msg         (msg),
    .status      (stat)
  );

  eis_flr u_flr (
    .clk       (clk),
    .rst       (rst),
    .ce        (ce),
    .start     (flr_start),
    .user_rdy  (func_reset_rdy),
    .reset_req (func_reset_req),
    .done      (flr_done)
  );

  assign flr_rdy_seen = func_reset_req & func_reset_rdy;

  always_comb begin
    events               = '0;
    events[IRQ_ASSERT]   = msg.valid & msg.is_assert;
    events[IRQ_DEASSERT] = msg.valid & ~msg.is_assert;
    events[IRQ_PME]      = pme_event & ~r_ff.pme_d;
    events[IRQ_FLR]      = flr_rdy_seen;
  end

  // read mux; paddr decode also flags unmapped offsets
  always_comb begin
    rdata    = '0;
    unmapped = 1'b0;
    case (paddr)
      OFF_CMD:      rdata[5:0]  = r_ff.mirror.cmd;
      OFF_DEV_CTL:  rdata[14:0] = r_ff.mirror.dev_ctl;
      OFF_LNK_CTL:  rdata[7:0]  = r_ff.mirror.lnk_ctl;
      OFF_DEV_CTL2: rdata[4:0]  = r_ff.mirror.dev_ctl2;
      OFF_MSI: begin
        rdata[MSI_EN_BIT]              = r_ff.msi_en;
        rdata[MSI_CNT_MSB:MSI_CNT_LSB] = r_ff.msi_cnt;
      end
      OFF_PM: begin
        rdata[PM_EN_BIT]   = r_ff.pme_en;
        rdata[PM_STAT_BIT] = r_ff.pme_stat;
      end
      OFF_INT_STAT: rdata[0] = stat;                   // see RL11
      OFF_FLR:      rdata[FLR_BUSY_BIT] = func_reset_req;
      OFF_IRQ_STAT: rdata[IRQ_W-1:0] = r_ff.irq_stat;
      OFF_IRQ_MASK: rdata[IRQ_W-1:0] = r_ff.irq_mask;
      default:      unmapped = 1'b1;
    endcase
  end

  assign prdata  = (psel & ~pwrite) ? rdata : 32'h0000_0000;
  assign pslverr = psel & penable & unmapped;

  always_comb begin
    nxt_r          = r_ff;
    nxt_r.pme_d    = pme_event;
    nxt_r.pme_stat = pme_event;                        // see RL16
    if (wr) begin
      case (paddr)
        OFF_CMD:      nxt_r.mirror.cmd      = pwdata[5:0];   // see RL1
        OFF_DEV_CTL:  nxt_r.mirror.dev_ctl  = pwdata[14:0];  // see RL2
        OFF_LNK_CTL:  nxt_r.mirror.lnk_ctl  = pwdata[7:0];   // see RL3
        OFF_DEV_CTL2: nxt_r.mirror.dev_ctl2 = pwdata[4:0];   // see RL4
        OFF_MSI: begin
          nxt_r.msi_en  = pwdata[MSI_EN_BIT];                // see RL15
          nxt_r.msi_cnt = pwdata[MSI_CNT_MSB:MSI_CNT_LSB];   // see RL14
        end
        OFF_PM:       nxt_r.pme_en   = pwdata[PM_EN_BIT];    // see RL17
        OFF_IRQ_MASK: nxt_r.irq_mask = pwdata[IRQ_W-1:0];
        default:      nxt_r.mirror   = r_ff.mirror;
      endcase
    end
    // function reset returns the control fields to reset; status and
    // interrupt bookkeeping survive so software can see what happened
    if (flr_done) begin
      nxt_r.mirror.cmd      = CMD_RST;
      nxt_r.mirror.dev_ctl  = DEV_CTL_RST;
      nxt_r.mirror.lnk_ctl  = LNK_CTL_RST;
      nxt_r.mirror.dev_ctl2 = DEV_CTL2_RST;
      nxt_r.msi_en          = MSI_EN_RST;
      nxt_r.msi_cnt         = MSI_CNT_RST;
      nxt_r.pme_en          = PM_EN_RST;
    end
    // write one to clear; a same-cycle event wins
    if (wr && paddr == OFF_IRQ_STAT) begin
      nxt_r.irq_stat = r_ff.irq_stat & ~pwdata[IRQ_W-1:0];
    end
    nxt_r.irq_stat = nxt_r.irq_stat | events;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      r_ff.mirror.cmd      <= CMD_RST;
      r_ff.mirror.dev_ctl  <= DEV_CTL_RST;
      r_ff.mirror.lnk_ctl  <= LNK_CTL_RST;
      r_ff.mirror.dev_ctl2 <= DEV_CTL2_RST;
      r_ff.msi_en          <= MSI_EN_RST;
      r_ff.msi_cnt         <= MSI_CNT_RST;
      r_ff.pme_en          <= PM_EN_RST;
      r_ff.pme_stat        <= 1'b0;
      r_ff.pme_d           <= 1'b0;
      r_ff.irq_stat        <= IRQ_STAT_RST;
      r_ff.irq_mask        <= IRQ_MASK_RST;
    end else if (ce) begin
      r_ff <= nxt_r;
    end
  end

  assign cfg_mirror           = r_ff.mirror;       // see RL1 see RL2
  assign granted_vector_count = r_ff.msi_cnt;      // see RL14
  assign msi_enabled          = r_ff.msi_en;       // see RL15
  assign pme_enable           = r_ff.pme_en;       // see RL17
  assign intx_msg             = msg;
  assign int_status           = stat;
  assign irq                  = |(r_ff.irq_stat & r_ff.irq_mask);

  AST_CMD_MIRROR: // see RL1
  assert property (@(posedge clk) disable iff (rst)
    wr && paddr == OFF_CMD && !flr_done
    |=> cfg_mirror.cmd == $past(pwdata[5:0]))
  else $error("command mirror not updated by write");

  AST_DEV_CTL_MIRROR: // see RL2
  assert property (@(posedge clk) disable iff (rst)
    wr && paddr == OFF_DEV_CTL && !flr_done
    ##1 !ce [*2] |-> cfg_mirror.dev_ctl == $past(pwdata[14:0], 2))
  else $error("device control mirror lost while frozen");

  AST_LNK_CTL_MIRROR: // see RL3
  assert property (@(posedge clk) disable iff (rst)
    wr && paddr == OFF_LNK_CTL && !flr_done
    |=> cfg_mirror.lnk_ctl == $past(pwdata[7:0]))
  else $error("link control mirror not updated by write");

  AST_DEV_CTL2_MIRROR: // see RL4
  assert property (@(posedge clk) disable iff (rst)
    wr && paddr == OFF_DEV_CTL2 && !flr_done
    |=> cfg_mirror.dev_ctl2 == $past(pwdata[4:0]))
  else $error("device control 2 mirror not updated by write");

  AST_SINGLE_LINE: // see RL11
  assert property (@(posedge clk) disable iff (rst)
    psel && !pwrite && paddr == OFF_INT_STAT
    |-> prdata[31:1] == 31'h0000_0000 && prdata[0] == int_status)
  else $error("interrupt status register shows more than one line");

  AST_MSI_COUNT: // see RL14
  assert property (@(posedge clk) disable iff (rst)
    wr && paddr == OFF_MSI && !flr_done
    |=> granted_vector_count == $past(pwdata[MSI_CNT_MSB:MSI_CNT_LSB])
        && msi_enabled == $past(pwdata[MSI_EN_BIT]))
  else $error("msi count or enable not updated by write");

  AST_PME_COPY: // see RL16
  assert property (@(posedge clk) disable iff (rst)
    ce && $rose(pme_event) |=> r_ff.pme_stat && r_ff.irq_stat[IRQ_PME])
  else $error("power event not captured in status");

  AST_PME_EN: // see RL17
  assert property (@(posedge clk) disable iff (rst)
    ce && flr_done
    |=> !pme_enable && !msi_enabled && cfg_mirror.cmd == CMD_RST)
  else $error("function reset did not clear control fields");

  AST_FLR_CLEAR: // see RL2
  assert property (@(posedge clk) disable iff (rst)
    ce && flr_done |=> cfg_mirror.dev_ctl == DEV_CTL_RST
        && cfg_mirror.lnk_ctl == LNK_CTL_RST
        && cfg_mirror.dev_ctl2 == DEV_CTL2_RST)
  else $error("function reset left a control mirror set");

  AST_FLR_DONE_ONCE: // see RL12
  assert property (@(posedge clk) disable iff (rst)
    ce && flr_done |=> !flr_done)
  else $error("function reset done lasted more than one cycle");

  AST_PM_EN_WR: // see RL17
  assert property (@(posedge clk) disable iff (rst)
    wr && paddr == OFF_PM && !flr_done |=> pme_enable == $past(pwdata[0]))
  else $error("pme enable not updated by write");

  AST_PME_STAT_CLR: // see RL16
  assert property (@(posedge clk) disable iff (rst)
    ce && !pme_event |=> !r_ff.pme_stat)
  else $error("pme status kept after power event ended");

  AST_INT_DIS_BIT: // see RL7
  assert property (@(posedge clk) disable iff (rst)
    ce && cfg_mirror.cmd[CMD_INT_DIS] |=> !intx_msg.valid)
  else $error("message sent while command disable bit set");

  AST_MSI_MUTE: // see RL15
  assert property (@(posedge clk) disable iff (rst)
    ce && msi_enabled |=> !intx_msg.valid)
  else $error("legacy message sent while msi enabled output high");

  // frozen block must neither lose nor gain state
  AST_FREEZE:
  assert property (@(posedge clk) disable iff (rst)
    !ce |=> $stable(r_ff))
  else $error("state changed while clock enable low");

  AST_UNMAPPED_WR:
  assert property (@(posedge clk) disable iff (rst)
    psel && penable && pwrite && ce && unmapped && !flr_done
    |=> $stable(r_ff.mirror))
  else $error("write to unmapped offset changed a mirror");

  AST_RD_ZERO:
  assert property (@(posedge clk) disable iff (rst)
    psel && !pwrite && unmapped |-> prdata == 32'h0000_0000)
  else $error("unmapped read returned nonzero data");

  AST_MASK_WR:
  assert property (@(posedge clk) disable iff (rst)
    wr && paddr == OFF_IRQ_MASK |=> r_ff.irq_mask == $past(pwdata[3:0]))
  else $error("interrupt mask not updated by write");

  AST_W1C:
  assert property (@(posedge clk) disable iff (rst)
    wr && paddr == OFF_IRQ_STAT && events == '0
    |=> (r_ff.irq_stat & $past(pwdata[3:0])) == '0)
  else $error("write one did not clear interrupt status");

  // a clear in the same cycle as an event must lose
  AST_SET_WINS:
  assert property (@(posedge clk) disable iff (rst)
    ce && events != '0 |=> (r_ff.irq_stat & $past(events)) == $past(events))
  else $error("interrupt event lost");

endmodule : eis_top

// ---- sim/eis_user_model.sv ----
module eis_user_model #(
  parameter int EDGE_GAP = 2  // 8 for native x1 parts
) (
  input  wire logic       clk,            // core clock
  input  wire logic       rst,            // sync reset
  input  wire logic       want_irq,       // bench wants interrupt
  input  wire logic       use_or,         // or request with disable bit
  input  wire logic       int_disable,    // command mirror bit 5
  input  wire logic       func_reset_req, // reset request from device
  input  wire logic [3:0] rdy_delay,      // cycles before ready
  output logic            inta_req_n,     // legacy request, low active
  output logic            func_reset_rdy  // ready for function reset
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [3:0] gap_ff;
  logic [3:0] wait_ff;
  logic       target;

  // or with disable forces a release, so status clears; the deassert message stays muted
  assign target = !want_irq || (use_or && int_disable);

  always_ff @(posedge clk) begin
    if (rst) begin
      inta_req_n     <= 1'b1;
      gap_ff         <= 4'h0;
      wait_ff        <= 4'h0;
      func_reset_rdy <= 1'b0;
    end else begin
      if (gap_ff != 4'h0) begin
        gap_ff <= gap_ff - 4'h1;
      end else if (inta_req_n != target) begin
        inta_req_n <= target;
        gap_ff     <= 4'(EDGE_GAP - 1);
      end
      if (!func_reset_req) begin
        wait_ff        <= 4'h0;
        func_reset_rdy <= 1'b0;
      end else if (wait_ff == rdy_delay) begin
        func_reset_rdy <= 1'b1;
      end else begin
        wait_ff <= wait_ff + 4'h1;
      end
    end
  end
endmodule : eis_user_model

// ---- sim/endpoint_interrupt_sideband_tb.sv ----
module endpoint_interrupt_sideband_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import eis_pkg::*;

  typedef struct packed {
    logic [7:0]  a;
    logic [31:0] d;
    logic [31:0] r;
    logic        e;
  } eis_row_t;

  localparam eis_row_t ROWS [7] = '{
    '{OFF_CMD,      32'hffff_ffc5, 32'h0000_0005, 1'b0},
    '{OFF_DEV_CTL,  32'hffff_ffff, 32'h0000_7fff, 1'b0},
    '{OFF_LNK_CTL,  32'h0000_01a5, 32'h0000_00a5, 1'b0},
    '{OFF_DEV_CTL2, 32'h0000_00f3, 32'h0000_0013, 1'b0},
    '{OFF_MSI,      32'h0000_000b, 32'h0000_000b, 1'b0},
    '{OFF_INT_STAT, 32'hffff_ffff, 32'h0000_0000, 1'b0},
    '{8'h28,        32'h1234_5678, 32'h0000_0000, 1'b1}
  };

  logic          clk = 1'b0;
  logic          rst = 1'b1;
  logic          ce = 1'b1;
  logic          psel = 1'b0;
  logic          penable = 1'b0;
  logic          pwrite = 1'b0;
  logic [7:0]    paddr = 8'h00;
  logic [31:0]   pwdata = 32'h0;
  logic          pready;
  logic [31:0]   prdata;
  logic          pslverr;
  logic          irq;
  logic          inta_req_n;
  eis_intx_msg_t intx_msg;
  logic          int_status;
  eis_mirror_t   cfg_mirror;
  logic [2:0]    granted_vector_count;
  logic          msi_enabled;
  logic          pme_event = 1'b0;
  logic          pme_enable;
  logic          func_reset_req;
  logic          func_reset_rdy;
  logic          want_irq = 1'b0;
  logic          use_or = 1'b0;
  logic [3:0]    rdy_delay = 4'h3;
  logic [31:0]   rd;
  logic          er;
  int            fail_count = 0;
  int            n_tests = 0;
  int            n_as = 0;
  int            n_de = 0;

  always #5 clk = ~clk;

  eis_top i_dut (.clk(clk), .rst(rst), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .irq(irq),
    .inta_req_n(inta_req_n), .intx_msg(intx_msg), .int_status(int_status),
    .cfg_mirror(cfg_mirror), .granted_vector_count(granted_vector_count),
    .msi_enabled(msi_enabled), .pme_event(pme_event),
    .pme_enable(pme_enable), .func_reset_req(func_reset_req),
    .func_reset_rdy(func_reset_rdy));

  eis_user_model i_user (.clk(clk), .rst(rst), .want_irq(want_irq),
    .use_or(use_or), .int_disable(cfg_mirror.cmd[CMD_INT_DIS]),
    .func_reset_req(func_reset_req), .rdy_delay(rdy_delay),
    .inta_req_n(inta_req_n), .func_reset_rdy(func_reset_rdy));

  always @(posedge clk) begin
    if (intx_msg.valid === 1'b1) begin
      if (intx_msg.is_assert) n_as++;
      else n_de++;
    end
  end

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : close_out

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int i;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    er = pslverr;
    if (i == 20) begin
      fail_count++;
      close_out();
    end
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // one request pulse; muted cases expect no messages
  task automatic pulse_irq(input int exp_n);
    int a0;
    int d0;
    a0 = n_as;
    d0 = n_de;
    want_irq <= 1'b1;
    repeat (6) @(posedge clk);
    chk(int_status, 64'h1);
    want_irq <= 1'b0;
    repeat (6) @(posedge clk);
    chk(int_status, 64'h0);
    chk(64'(n_as - a0), 64'(exp_n));
    chk(64'(n_de - d0), 64'(exp_n));
  endtask : pulse_irq

  initial begin
    int i;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    foreach (ROWS[k]) begin
      apb(1'b1, ROWS[k].a, ROWS[k].d);
      chk(er, ROWS[k].e);
      apb(1'b0, ROWS[k].a, 32'h0);
      chk(rd, ROWS[k].r);
      chk(er, ROWS[k].e);
    end
    chk(cfg_mirror, {6'h05, 15'h7fff, 8'ha5, 5'h13});
    chk({granted_vector_count, msi_enabled}, 64'hb);
    // frozen block keeps a fresh write and stalls the bus
    apb(1'b1, OFF_DEV_CTL, 32'h0000_1234);
    ce <= 1'b0;
    repeat (2) @(posedge clk);
    chk(cfg_mirror.dev_ctl, 64'h1234);
    chk(pready, 64'h0);
    ce <= 1'b1;
    pulse_irq(0);
    apb(1'b1, OFF_MSI, 32'h0);
    pulse_irq(1);
    apb(1'b0, OFF_IRQ_STAT, 32'h0);
    chk(rd, 64'h3);
    chk(irq, 64'h0);
    apb(1'b1, OFF_IRQ_MASK, 32'h3);
    @(posedge clk);
    chk(irq, 64'h1);
    apb(1'b1, OFF_IRQ_STAT, 32'h3);
    @(posedge clk);
    chk(irq, 64'h0);
    apb(1'b1, OFF_CMD, 32'h25);
    pulse_irq(0);
    // request held while disable rises: or-ing releases it
    apb(1'b1, OFF_CMD, 32'h05);
    use_or   <= 1'b1;
    want_irq <= 1'b1;
    repeat (6) @(posedge clk);
    chk(int_status, 64'h1);
    apb(1'b1, OFF_CMD, 32'h25);
    repeat (6) @(posedge clk);
    chk(int_status, 64'h0);
    want_irq <= 1'b0;
    apb(1'b1, OFF_PM, 32'h1);
    @(posedge clk);
    chk(pme_enable, 64'h1);
    pme_event <= 1'b1;
    repeat (3) @(posedge clk);
    apb(1'b0, OFF_PM, 32'h0);
    chk(rd, 64'h3);
    pme_event <= 1'b0;
    repeat (3) @(posedge clk);
    apb(1'b0, OFF_PM, 32'h0);
    chk(rd, 64'h1);
    apb(1'b1, OFF_FLR, 32'h1);
    @(posedge clk);
    chk(func_reset_req, 64'h1);
    apb(1'b0, OFF_FLR, 32'h0);
    chk(rd, 64'h2);
    for (i = 0; i < 50 && func_reset_req !== 1'b0; i++) @(posedge clk);
    if (i == 50) begin
      fail_count++;
      close_out();
    end
    repeat (2) @(posedge clk);
    chk(cfg_mirror, 64'h0);
    chk({granted_vector_count, msi_enabled, pme_enable}, 64'h0);
    apb(1'b0, OFF_IRQ_STAT, 32'h0);
    chk(rd[3], 64'h1);
    apb(1'b1, OFF_CMD, 32'h3f);
    apb(1'b1, OFF_IRQ_MASK, 32'hf);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk(cfg_mirror, 64'h0);
    chk({irq, int_status, func_reset_req}, 64'h0);
    close_out();
  end

  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    close_out();
  end
endmodule : endpoint_interrupt_sideband_tb
